/* File: rtl/port_zero_pin_mux_gpio.sv */
// Purpose: Port zero pin multiplexer with GPIO, plus SPI steering of port one.
// Assumes: Special-function bus on the CPU clock; pins are asynchronous.
// Notes: Output enable high means the block drives the pin.
// Functional notes
// [R01] All pins are inputs while reset is asserted, clock or not.
// [R02] After reset pins stay inputs until software writes direction or select.
// [R03] Alternate-select bit outranks the direction bit.
// [R04] With alternate selected, direction follows the selected peripheral.
// [R05] UART receive pin direction still follows direction bit 1.
// [R06] Interrupt inputs reach interrupt logic only when select bit 3 or 4 set.
// [R07] With alternate clear, pin is GPIO with direction from direction bit.
// [R08] Direction bit 0 means output, 1 means input.
// [R09] Bit 0 is always GPIO, the boot memory select.
// [R10] Bits 1..7: rx, tx out, int a, int b, timer 0, timer 1, PWM out.
// [R11] Data, direction, select registers at 0x80, 0x94, 0x95.
// [R12] Data bit 7 drives the highest pin, bit 0 the lowest.
// [R13] SPI route 01 turns port one into SPI data-in, clock, data-out.
// [R14] GPIO outputs drive the data bit; input reads return the pin level.
`include "port_zero_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module port_zero_pin_mux_gpio
	import port_zero_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// Special-function register bus
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire port_zero_pkg::byte_t sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	output logic sfr_hit_o,
	// Port zero pins, bit 0 lowest pin
	input wire port_zero_pkg::byte_t port_zero_pin_i,
	output port_zero_pkg::byte_t port_zero_pin_o,
	output port_zero_pkg::byte_t port_zero_pin_oe_o,
	// Peripheral side of the alternate functions
	input wire logic uart_tx_i,
	input wire logic uart_rx_out_i,
	input wire logic pwm_i,
	output logic uart_rx_o,
	output logic external_interrupt_a_o,
	output logic external_interrupt_b_o,
	output logic timer_zero_count_in_o,
	output logic timer_one_count_in_o,
	// Port one SPI steering
	input wire logic [1:0] spi_route_i,
	input wire logic spi_clk_i,
	input wire logic spi_data_out_i,
	input wire port_zero_pkg::byte_t port_one_gpio_out_i,
	input wire port_zero_pkg::byte_t port_one_gpio_oe_i,
	input wire logic [2:0] port_one_pin_i,
	output logic [2:0] port_one_pin_o,
	output logic [2:0] port_one_pin_oe_o,
	output logic [2:0] port_one_level_o,
	output logic spi_data_in_o
);
	import port_zero_pkg::*;

	state_t s_r;
	state_t s_nxt;
	byte_t oe;
	byte_t dout;
	logic spi_on;

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.pin_meta_r = port_zero_pin_i;
		s_nxt.pin_sync_r = s_r.pin_meta_r;
		s_nxt.p1_meta_r = port_one_pin_i;
		s_nxt.p1_sync_r = s_r.p1_meta_r;
		if (sfr_wr_i)
		begin
			unique case (sfr_addr_i) // [R11]
				`PZ_DATA_ADDR: s_nxt.data_r = sfr_wdata_i;
				`PZ_DIR_ADDR: s_nxt.dir_r = sfr_wdata_i; // [R02]
				`PZ_ALT_ADDR: s_nxt.alt_r = sfr_wdata_i; // [R02]
				default: s_nxt.rdata_r = s_r.rdata_r;
			endcase
		end
		if (sfr_rd_i)
		begin
			unique case (sfr_addr_i) // [R11]
				`PZ_DATA_ADDR: s_nxt.rdata_r = (s_r.data_r & ~oe) | (s_r.pin_sync_r & ~oe)
					| (s_r.data_r & oe); // [R14]
				`PZ_DIR_ADDR: s_nxt.rdata_r = s_r.dir_r;
				`PZ_ALT_ADDR: s_nxt.rdata_r = s_r.alt_r;
				default: s_nxt.rdata_r = 8'h00;
			endcase
			if (sfr_addr_i == `PZ_DATA_ADDR)
				s_nxt.rdata_r = (s_r.pin_sync_r & ~oe) | (s_r.data_r & oe); // [R14]
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			s_r <= '0;
			s_r.data_r <= `PZ_DATA_RESET;
			s_r.dir_r <= `PZ_DIR_RESET;
			s_r.alt_r <= `PZ_ALT_RESET;
		end
		else
			s_r <= s_nxt;
	end

	// Output enables and output data per pin; select outranks direction except on the receive pin, bit 1.
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			oe[i] = ~s_r.dir_r[i]; // [R07] [R08]
			dout[i] = s_r.data_r[i]; // [R12] [R14]
		end
		if (s_r.alt_r[`PZ_BIT_RX])
		begin
			oe[`PZ_BIT_RX] = ~s_r.dir_r[`PZ_BIT_RX]; // [R05]
			dout[`PZ_BIT_RX] = uart_rx_out_i;
		end
		if (s_r.alt_r[`PZ_BIT_TX]) // [R03] [R04] [R10]
		begin
			oe[`PZ_BIT_TX] = 1'b1;
			dout[`PZ_BIT_TX] = uart_tx_i;
		end
		if (s_r.alt_r[`PZ_BIT_INT_A])
			oe[`PZ_BIT_INT_A] = 1'b0; // [R04]
		if (s_r.alt_r[`PZ_BIT_INT_B])
			oe[`PZ_BIT_INT_B] = 1'b0; // [R04]
		if (s_r.alt_r[`PZ_BIT_TMR0])
			oe[`PZ_BIT_TMR0] = 1'b0; // [R04]
		if (s_r.alt_r[`PZ_BIT_TMR1])
			oe[`PZ_BIT_TMR1] = 1'b0; // [R04]
		if (s_r.alt_r[`PZ_BIT_PWM]) // [R10]
		begin
			oe[`PZ_BIT_PWM] = 1'b1;
			dout[`PZ_BIT_PWM] = pwm_i;
		end
	end
	// Bit 0 is untouched by the select register above. [R09]

	// Reset forces every pin to input even without a clock edge.
	assign port_zero_pin_oe_o = reset_i ? 8'h00 : oe; // [R01]
	assign port_zero_pin_o = dout;
	assign sfr_rdata_o = s_r.rdata_r;
	assign sfr_hit_o = (sfr_addr_i == `PZ_DATA_ADDR) || (sfr_addr_i == `PZ_DIR_ADDR)
		|| (sfr_addr_i == `PZ_ALT_ADDR);

	// Interrupts idle high when not selected, as they are active low. [R06]
	assign external_interrupt_a_o = s_r.alt_r[`PZ_BIT_INT_A] ? s_r.pin_sync_r[`PZ_BIT_INT_A] : 1'b1;
	assign external_interrupt_b_o = s_r.alt_r[`PZ_BIT_INT_B] ? s_r.pin_sync_r[`PZ_BIT_INT_B] : 1'b1;
	assign uart_rx_o = s_r.alt_r[`PZ_BIT_RX] ? s_r.pin_sync_r[`PZ_BIT_RX] : 1'b1;
	assign timer_zero_count_in_o = s_r.alt_r[`PZ_BIT_TMR0] & s_r.pin_sync_r[`PZ_BIT_TMR0];
	assign timer_one_count_in_o = s_r.alt_r[`PZ_BIT_TMR1] & s_r.pin_sync_r[`PZ_BIT_TMR1];

	// Port one: pin 0 clock, pin 1 data out, pin 2 data in under SPI routing.
	assign spi_on = (spi_route_i == `PZ_SPI_ROUTE_PORT); // [R13]
	assign port_one_pin_o = spi_on ? {1'b0, spi_data_out_i, spi_clk_i}
		: port_one_gpio_out_i[2:0];
	assign port_one_pin_oe_o = reset_i ? 3'h0 : (spi_on ? 3'h3
		: {1'b0, port_one_gpio_oe_i[1:0]}); // [R13] [R01]
	assign port_one_level_o = s_r.p1_sync_r;
	assign spi_data_in_o = s_r.p1_sync_r[2];
endmodule : port_zero_pin_mux_gpio
`default_nettype wire

/* File: rtl/port_zero_regs.svh */
// Purpose: Offsets, reset values and field positions of the port zero block.
// Assumes: Special-function bus with 8-bit addresses and 8-bit data.
// Notes: Included by the port module and the property checks.
`ifndef PORT_ZERO_REGS_SVH
`define PORT_ZERO_REGS_SVH
`define PZ_DATA_ADDR 8'h80
`define PZ_DIR_ADDR 8'h94
`define PZ_ALT_ADDR 8'h95
`define PZ_DATA_RESET 8'hff
`define PZ_DIR_RESET 8'hff
`define PZ_ALT_RESET 8'h00
`define PZ_SPI_ROUTE_PORT 2'h1
`define PZ_BIT_BOOT 0
`define PZ_BIT_RX 1
`define PZ_BIT_TX 2
`define PZ_BIT_INT_A 3
`define PZ_BIT_INT_B 4
`define PZ_BIT_TMR0 5
`define PZ_BIT_TMR1 6
`define PZ_BIT_PWM 7
`endif

/* File: rtl/port_zero_pkg.sv */
// Purpose: Types shared by the port zero block.
// Assumes: Nothing beyond the register header.
// Notes: Holds the packed state of the port module.
package port_zero_pkg;
	typedef logic [7:0] byte_t;
	typedef struct packed {
		byte_t data_r;
		byte_t dir_r;
		byte_t alt_r;
		byte_t pin_meta_r;
		byte_t pin_sync_r;
		logic [2:0] p1_meta_r;
		logic [2:0] p1_sync_r;
		byte_t rdata_r;
	} state_t;
endpackage : port_zero_pkg

/* File: dv/pin_world.sv */
// Purpose: Outside world seen by the port zero pins.
// Assumes: One level per pin from the bench.
// Notes: Driven pins show the block's value.
`timescale 1ns/1ps
`default_nettype none
module pin_world
	import port_zero_pkg::*;
(
	input wire port_zero_pkg::byte_t drive_i, oe_i, ext_i,
	output port_zero_pkg::byte_t level_o
);
	assign level_o = (drive_i & oe_i) | (ext_i & ~oe_i);
endmodule : pin_world
`default_nettype wire

/* File: dv/port_zero_pin_mux_gpio_properties.sv */
// Purpose: Port checks of the port zero block.
// Assumes: Shadows follow register writes.
// Notes: Bound to the block.
`include "port_zero_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module pz_props
	import port_zero_pkg::*;
(
	input wire logic core_clk_i, reset_i, sfr_wr_i, sfr_rd_i, uart_tx_i, pwm_i, sfr_hit_o,
	input wire logic external_interrupt_a_o, external_interrupt_b_o, timer_zero_count_in_o,
	input wire logic [7:0] sfr_addr_i, sfr_rdata_o,
	input wire port_zero_pkg::byte_t sfr_wdata_i, port_zero_pin_o, port_zero_pin_oe_o,
	input wire logic [1:0] spi_route_i,
	input wire logic spi_clk_i, spi_data_out_i,
	input wire logic [2:0] port_one_pin_o, port_one_pin_oe_o
);
	byte_t dat_r, dir_r, alt_r, oe_exp;
	always_ff @(posedge core_clk_i or posedge reset_i)
		if (reset_i) {dat_r, dir_r, alt_r} <= {`PZ_DATA_RESET, `PZ_DIR_RESET, `PZ_ALT_RESET};
		else if (sfr_wr_i && sfr_addr_i == `PZ_DATA_ADDR) dat_r <= sfr_wdata_i;
		else if (sfr_wr_i && sfr_addr_i == `PZ_DIR_ADDR) dir_r <= sfr_wdata_i;
		else if (sfr_wr_i && sfr_addr_i == `PZ_ALT_ADDR) alt_r <= sfr_wdata_i;
	// Inputs of interrupts and timers never drive; transmit and PWM always do.
	assign oe_exp = (~dir_r & ~(alt_r & 8'h78)) | (alt_r & 8'h84);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	oe_reset_a: assert property (disable iff (1'b0) reset_i |-> port_zero_pin_oe_o == 8'h00)
		else $error("pin driven in reset");
	hit_decode_a: assert property (sfr_hit_o == (sfr_addr_i inside {8'h80, 8'h94, 8'h95}))
		else $error("bad decode");
	oe_map_a: assert property (port_zero_pin_oe_o == oe_exp)
		else $error("bad direction");
	alt_out_a: assert property (alt_r[2] || alt_r[7] |-> (!alt_r[2] || port_zero_pin_o[2] == uart_tx_i) && (!alt_r[7] || port_zero_pin_o[7] == pwm_i))
		else $error("bad alternate output");
	gpio_drive_a: assert property (((port_zero_pin_o ^ dat_r) & oe_exp & ~(alt_r & 8'hfe)) == 8'h00)
		else $error("bad drive value");
	int_gate_a: assert property ((alt_r[3] || external_interrupt_a_o) && (alt_r[4] || external_interrupt_b_o) && (alt_r[5] || !timer_zero_count_in_o))
		else $error("ungated input");
	spi_route_a: assert property (spi_route_i == 2'h1 |-> port_one_pin_oe_o == 3'b011 && port_one_pin_o[1:0] == {spi_data_out_i, spi_clk_i})
		else $error("bad spi steering");
	rd_back_a: assert property (sfr_rd_i && sfr_addr_i == `PZ_ALT_ADDR |=> sfr_rdata_o == $past(alt_r))
		else $error("bad readback");
	cover property (spi_route_i == 2'h1);
	cover property (alt_r[3] && !external_interrupt_a_o);
	cover property (sfr_rd_i && !sfr_hit_o);
endmodule : pz_props
bind port_zero_pin_mux_gpio pz_props pz_props_inst (.core_clk_i, .reset_i, .sfr_wr_i, .sfr_rd_i,
	.uart_tx_i, .pwm_i, .sfr_hit_o, .external_interrupt_a_o, .external_interrupt_b_o,
	.timer_zero_count_in_o, .sfr_addr_i, .sfr_rdata_o, .sfr_wdata_i, .port_zero_pin_o,
	.port_zero_pin_oe_o, .spi_route_i, .spi_clk_i, .spi_data_out_i, .port_one_pin_o, .port_one_pin_oe_o);
`default_nettype wire

/* File: dv/port_zero_pin_mux_gpio_bench.sv */
// Purpose: Register-level tests of the port zero block.
// Assumes: Outside pins hold a5.
// Notes: Inputs change 1 ns after the edge; SPI clock and data out change 2 ns after it.
`timescale 1ns/1ps
`default_nettype none
module port_zero_pin_mux_gpio_bench;
	import port_zero_pkg::*;
	logic clk = 0, rst = 1, wr = 0, rd = 0, tx = 1, pwm = 0, sclk = 1, sdo = 0, hit, ia, ib;
	logic [7:0] addr = 8'h00, rdata;
	logic [1:0] route = 2'h0;
	logic [2:0] p1_o, p1_oe, p1_lvl, p1_in = 3'h4;
	logic rx_in, t0, t1, sdi;
	byte_t wdata = 8'h00, pin_o, pin_oe, pin_lvl, ext = 8'ha5;
	int n_errors = 0, n_tests = 0;
	always #5 clk = ~clk;
	pin_world pin_world_inst (.drive_i(pin_o), .oe_i(pin_oe), .ext_i(ext), .level_o(pin_lvl));
	port_zero_pin_mux_gpio port_zero_pin_mux_gpio_inst (.core_clk_i(clk), .reset_i(rst),
		.sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
		.sfr_hit_o(hit), .port_zero_pin_i(pin_lvl), .port_zero_pin_o(pin_o),
		.port_zero_pin_oe_o(pin_oe), .uart_tx_i(tx), .uart_rx_out_i(1'b1), .pwm_i(pwm),
		.uart_rx_o(rx_in), .external_interrupt_a_o(ia), .external_interrupt_b_o(ib),
		.timer_zero_count_in_o(t0), .timer_one_count_in_o(t1), .spi_route_i(route), .spi_clk_i(sclk),
		.spi_data_out_i(sdo), .port_one_gpio_out_i(8'h00), .port_one_gpio_oe_i(8'h00),
		.port_one_pin_i(p1_in), .port_one_pin_o(p1_o), .port_one_pin_oe_o(p1_oe),
		.port_one_level_o(p1_lvl), .spi_data_in_o(sdi));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 {addr, wdata, wr, rd} = {a, d, w, !w};
		@(posedge clk);
		#1 {wr, rd} = 2'b00;
	endtask : acc
	task automatic report_and_stop;
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	initial
	begin
		#2 chk(pin_oe, 8'h00);
		repeat (2) @(posedge clk);
		#1 rst = 0;
		chk(pin_oe, 8'h00);
		acc(0, 8'h94, 0); chk(rdata, 8'hff);
		acc(0, 8'h95, 0); chk(rdata, 8'h00);
		acc(0, 8'h80, 0); chk(rdata, 8'ha5);
		acc(0, 8'h90, 0); chk(rdata, 8'h00);
		chk({6'h0, ib, ia}, 8'h03);
		acc(1, 8'h94, 8'h00);
		acc(1, 8'h80, 8'h3c);
		chk(pin_oe, 8'hff); chk(pin_o, 8'h3c);
		acc(0, 8'h80, 0); chk(rdata, 8'h3c);
		acc(1, 8'h95, 8'hff); chk(pin_oe, 8'h87);
		chk(pin_o & 8'h87, 8'h06);
		repeat (3) @(posedge clk);
		#1 chk({6'h0, ib, ia}, 8'h00);
		chk({5'h0, rx_in, t1, t0}, 8'h05);
		acc(1, 8'h94, 8'hff); chk(pin_oe, 8'h84);
		route = 2'h1;
		#1 chk({3'h0, p1_oe, p1_o[1:0]}, 8'h0d);
		{sclk, sdo} = 2'b01;
		#1 chk({3'h0, p1_oe, p1_o[1:0]}, 8'h0e);
		repeat (2) @(posedge clk);
		#1 chk({4'h0, sdi, p1_lvl}, 8'h0c);
		rst = 1;
		#1 chk(pin_oe, 8'h00);
		report_and_stop();
	end
	initial
	begin
		#5000 n_errors++;
		report_and_stop();
	end
endmodule : port_zero_pin_mux_gpio_bench
`default_nettype wire
